/* File: hss_mode_ctrl.sv */
`include "hss_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module hss_mode_ctrl #(
  parameter int WD_TIMEOUT_CYC = `HSS_WD_TIME_US * `HSS_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic wake_reset_n_pin,
  input wire logic limp_home_pin,
  input wire logic [3:0] direct_channel_inputs,
  input wire logic [3:0] overcurrent_window_inputs,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic [3:0] overtemp_fault,
  input wire logic [3:0] high_overcurrent_detect,
  input wire logic [3:0] severe_short_fault,
  input wire logic [3:0] overload_fault,
  input wire logic undervoltage,
  output logic [5:0] channel_control,
  output logic [4:0] ocw_start,
  output logic overcurrent_max_profile,
  output logic [3:0] autorestart_enable,
  output logic pwm_enable,
  output logic analog_feedback_enable,
  output logic fault_blank,
  output logic init_done
);

  // pin synchronisers: stage 0 is read only by stage 1
  logic [1:0] s_rstn, s_limp, s_sclk, s_cs, s_si;
  logic [1:0] s_din [4];
  logic [1:0] s_ocw [4];
  logic sclk_d, cs_d;
  always_ff @(posedge core_clk) begin
    s_rstn <= {s_rstn[0], wake_reset_n_pin};
    s_limp <= {s_limp[0], limp_home_pin};
    s_sclk <= {s_sclk[0], spi_sclk};
    s_cs <= {s_cs[0], spi_cs_n};
    s_si <= {s_si[0], spi_si};
    sclk_d <= s_sclk[1];
    cs_d <= s_cs[1];
  end
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge core_clk) begin
      s_din[i] <= {s_din[i][0], direct_channel_inputs[i]};
      s_ocw[i] <= {s_ocw[i][0], overcurrent_window_inputs[i]};
    end
  end

  wire logic rstn_s = s_rstn[1];
  wire logic limp_s = s_limp[1];
  wire logic [3:0] din_s = {s_din[3][1], s_din[2][1], s_din[1][1], s_din[0][1]};
  wire logic [3:0] ocw_s = {s_ocw[3][1], s_ocw[2][1], s_ocw[1][1], s_ocw[0][1]};
  wire logic sclk_rise = s_sclk[1] & ~sclk_d;
  wire logic cs_fall = ~s_cs[1] & cs_d;
  wire logic cs_rise = s_cs[1] & ~cs_d;

  wire logic wake = (|ocw_s) | rstn_s;

  hss_pkg::hss_mode_e mode, next_mode;
  hss_pkg::hss_cause_s cause;
  logic wake_d;
  logic [15:0] sh;
  logic [7:0] bit_cnt;
  logic [15:0] rx_last, tx_word;
  logic wd_last, rec_armed, read_qs, device_status_flag, register_cleared_flag, so_q;
  logic [31:0] wd_cnt, rec_cnt;
  logic [11:0] init_cnt, blank_cnt;
  logic [3:0] soa, inen, latch_off;
  logic [5:0] on_bits;
  logic [4:0] qsf;
  logic [3:0] ocw_prev;
  logic [5:0] ch_prev;
  logic [31:0] cfg;

  wire logic spi_fail = |cause;
  wire logic fail_state = spi_fail | limp_s;
  wire logic is_sleep = mode == hss_pkg::HSS_SLEEP;
  wire logic is_normal = mode == hss_pkg::HSS_NORMAL;
  wire logic is_fail = mode == hss_pkg::HSS_FAIL;
  wire logic wake_up = wake & ~wake_d;

  wire logic frame_end = cs_rise & rstn_s;
  wire logic frame_ok = frame_end && bit_cnt != 8'h00 && bit_cnt[3:0] == 4'h0;
  wire logic frame_bad = frame_end && bit_cnt[3:0] != 4'h0;
  wire logic frame_stuck = frame_ok && (sh == 16'h0000 || sh == 16'hffff);
  wire hss_pkg::hss_word_s rx = hss_pkg::hss_word_s'(sh);
  wire logic good_word = frame_ok & ~frame_stuck;
  wire logic is_write = good_word && rx.addr != `HSS_ADDR_TEST;

  wire logic wd_en = cfg[`HSS_CFG_WD_EN];
  wire logic seq_err = is_normal & is_write & wd_en & (rx.wd == wd_last);
  wire logic wd_expired = is_normal & wd_en & (wd_cnt >= WD_TIMEOUT_CYC - 1);
  wire logic cmd_write = is_normal & is_write & ~seq_err;

  wire logic recover = is_fail & ~limp_s & rec_armed & is_write & rx.wd & (rec_cnt < WD_TIMEOUT_CYC);
  wire logic enter_fail = is_normal & fail_state;
  wire logic clr_spi = wake_up | recover | ~rstn_s;
  wire logic clr_cmd = clr_spi | enter_fail;
  wire logic blanking = blank_cnt != 12'h000;

  always_comb begin
    next_mode = mode;
    if (!wake) begin
      next_mode = hss_pkg::HSS_SLEEP;
    end else begin
      unique case (mode)
        hss_pkg::HSS_SLEEP: next_mode = fail_state ? hss_pkg::HSS_FAIL : hss_pkg::HSS_NORMAL;
        hss_pkg::HSS_NORMAL: next_mode = fail_state ? hss_pkg::HSS_FAIL : hss_pkg::HSS_NORMAL;
        hss_pkg::HSS_FAIL: next_mode = recover ? hss_pkg::HSS_NORMAL : hss_pkg::HSS_FAIL;
        default: next_mode = hss_pkg::HSS_SLEEP;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode <= hss_pkg::HSS_SLEEP;
      wake_d <= 1'b0;
    end else begin
      mode <= next_mode;
      wake_d <= wake;
    end
  end

  // init and blanking timers restart on wake-up
  always_ff @(posedge core_clk) begin
    if (rst || !wake) begin
      init_cnt <= 12'h000;
      blank_cnt <= 12'h000;
      init_done <= 1'b0;
    end else if (wake_up) begin
      init_cnt <= 12'(`HSS_INIT_CYC - 1);
      blank_cnt <= 12'(`HSS_BLANK_CYC);
      init_done <= 1'b0;
    end else begin
      if (init_cnt != 12'h000) begin
        init_cnt <= init_cnt - 12'h001;
      end
      if (blanking) begin
        blank_cnt <= blank_cnt - 12'h001;
      end
      init_done <= init_cnt == 12'h000;
    end
  end
  assign fault_blank = blanking;

  // shift register; msb moves to so_q on the rising edge, so d15 is seen first
  always_ff @(posedge core_clk) begin
    if (rst || !rstn_s) begin
      sh <= 16'h0000;
      so_q <= 1'b0;
      bit_cnt <= 8'h00;
      read_qs <= 1'b0;
    end else if (cs_fall) begin
      sh <= tx_word;
      bit_cnt <= 8'h00;
      read_qs <= soa == `HSS_ADDR_QSTAT;
    end else if (!s_cs[1] && sclk_rise) begin
      so_q <= sh[15];
      sh <= {sh[14:0], s_si[1]};
      bit_cnt <= bit_cnt + 8'h01;
    end
  end
  // stuck lines kill the output driver too
  assign spi_so = so_q;
  assign spi_so_oe = ~s_cs[1] & rstn_s & ~cause.stuck;

  // failure causes, cleared by recovery or pin reset
  always_ff @(posedge core_clk) begin
    if (rst || clr_spi) begin
      cause <= '0;
    end else if (is_normal) begin
      cause.stuck <= cause.stuck | frame_stuck;
      cause.modulo <= cause.modulo | frame_bad;
      cause.wd_seq <= cause.wd_seq | seq_err;
      cause.wd_timeout <= cause.wd_timeout | wd_expired;
    end
  end

  // a host that never writes still trips the timeout: that is the point
  always_ff @(posedge core_clk) begin
    if (rst || clr_spi || cmd_write || !is_normal) begin
      wd_cnt <= 32'h0;
    end else if (!wd_expired) begin
      wd_cnt <= wd_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || clr_spi) begin
      wd_last <= 1'b1;
    end else if (cmd_write || (is_fail && is_write)) begin
      wd_last <= rx.wd;
    end
  end

  // arm on toggle 0, count one watchdog period
  always_ff @(posedge core_clk) begin
    if (rst || !is_fail || recover) begin
      rec_armed <= 1'b0;
      rec_cnt <= 32'h0;
    end else if (is_write && !rx.wd) begin
      rec_armed <= 1'b1;
      rec_cnt <= 32'h0;
    end else if (rec_armed && rec_cnt < WD_TIMEOUT_CYC) begin
      rec_cnt <= rec_cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || clr_cmd) begin
      soa <= 4'h0;
      inen <= 4'h0;
      on_bits <= 6'h00;
    end else if (cmd_write) begin
      if (rx.addr == `HSS_ADDR_INIT1) begin
        soa <= rx.data[3:0];
      end
      if (rx.addr >= `HSS_ADDR_CH1 && rx.addr <= `HSS_ADDR_CH6) begin
        on_bits[3'(rx.addr - `HSS_ADDR_CH1)] <= rx.data[`HSS_CH_ON_BIT];
      end
      if (rx.addr == `HSS_ADDR_OUTCTL) begin
        on_bits <= rx.data[5:0];
      end
      if (rx.addr == `HSS_ADDR_INEN) begin
        inen <= {rx.data[6], rx.data[4], rx.data[2], rx.data[0]};
      end
    end
  end

  // flags: the set beats a read that lands in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst || wake_up || !rstn_s) begin
      device_status_flag <= 1'b0;
      register_cleared_flag <= 1'b0;
    end else if (recover) begin
      device_status_flag <= 1'b1;
      register_cleared_flag <= 1'b1;
    end else if (frame_ok && read_qs) begin
      register_cleared_flag <= 1'b0;
    end
  end

  // fault capture outside blanking; latch-off only in Fail
  wire logic [3:0] hard_fault = overtemp_fault | high_overcurrent_detect | severe_short_fault;
  always_ff @(posedge core_clk) begin
    if (rst || clr_spi) begin
      qsf <= 5'h00;
      latch_off <= 4'h0;
    end else if (!blanking) begin
      qsf <= qsf | {undervoltage, hard_fault | overload_fault};
      if (is_fail) begin
        latch_off <= latch_off | hard_fault;
      end
    end
  end

  // outgoing word chosen by the address select bits
  wire logic sel_dsf = soa >= `HSS_ADDR_QSTAT && soa <= `HSS_ADDR_LAST_DSF;
  wire logic sel_qs = soa == `HSS_ADDR_QSTAT;
  always_comb begin
    tx_word = {soa, 12'h000};
    tx_word[`HSS_DSF_BIT] = sel_dsf & device_status_flag;
    if (sel_qs) begin
      tx_word[`HSS_QS_FM_BIT] = is_fail;
      tx_word[`HSS_QS_RCF_BIT] = register_cleared_flag;
      tx_word[4:0] = qsf;
    end
  end

  logic [5:0] next_ch;
  always_comb begin
    next_ch = 6'h00;
    if (is_normal) begin
      next_ch = on_bits | {2'b00, inen & din_s};
    end else if (is_fail) begin
      next_ch = {2'b00, din_s & ~latch_off};
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_control <= 6'h00;
      ch_prev <= 6'h00;
      ocw_prev <= 4'h0;
    end else begin
      channel_control <= next_ch;
      ch_prev <= channel_control;
      ocw_prev <= ocw_s;
    end
  end

  assign ocw_start = is_fail ? {1'b0, ocw_s & ~ocw_prev} : (channel_control[4:0] & ~ch_prev[4:0]);

  assign overcurrent_max_profile = is_fail;
  assign autorestart_enable = {4{is_fail}} & (overload_fault | {4{undervoltage}});
  assign pwm_enable = is_normal;
  assign analog_feedback_enable = is_normal;

  // avalon slave: one wait cycle, then answer
  logic bus_ack;
  wire logic bus_req = avs_read | avs_write;
  wire logic [31:0] status_word = {17'h0, qsf, init_done, device_status_flag, register_cleared_flag, ~cause.stuck, spi_fail, fail_state, wake, mode};
  wire logic [31:0] rd_mux = avs_address == `HSS_OFS_STATUS ? status_word :
                             avs_address == `HSS_OFS_CONFIG ? cfg :
                             avs_address == `HSS_OFS_RXWORD ? {16'h0, rx_last} : 32'h0;
  assign avs_waitrequest = bus_req & ~bus_ack;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bus_ack <= 1'b0;
      avs_readdata <= 32'h0;
      cfg <= `HSS_CONFIG_RESET;
      rx_last <= 16'h0000;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
      avs_readdata <= rd_mux;
      if (avs_write && bus_ack && avs_address == `HSS_OFS_CONFIG) begin
        cfg <= {31'h0, avs_writedata[`HSS_CFG_WD_EN]};
      end
      if (frame_ok) begin
        rx_last <= sh;
      end
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sleep_entry_a: assert property (!wake |=> is_sleep) else $error("no sleep without wake");
  limp_fail_a: assert property (limp_s && wake |=> is_fail) else $error("limp did not force fail");
  sleep_off_a: assert property (is_sleep |=> channel_control == 6'h00) else $error("outputs on in sleep");
  normal_cond_a: assert property (is_normal |-> $past(wake) && !$past(fail_state)) else $error("bad normal");
  fail_outs_a: assert property (is_fail [*2] |-> channel_control[5:4] == 2'b00) else $error("ch5/6 on");
  win_start_a: assert property (is_normal && $rose(channel_control[0]) |-> ocw_start[0]) else $error("no window");
  fail_write_a: assert property (is_fail && is_write && !recover |=> $stable(on_bits)) else $error("write in fail");
  recover_flags_a: assert property (recover |=> is_normal && register_cleared_flag && device_status_flag) else $error("recovery flags");
  rcf_hold_a: assert property (register_cleared_flag && !(frame_ok && read_qs) && rstn_s && !wake_up |=> register_cleared_flag) else $error("rcf lost");
  modulo_fail_a: assert property (is_normal && frame_bad && !clr_spi |=> cause.modulo) else $error("modulo");
  bus_wait_a: assert property (bus_req && !bus_ack |=> bus_req |-> !avs_waitrequest) else $error("bus stall");

  normal_c: cover property (is_sleep ##1 is_normal);
  fail_c: cover property (is_normal ##1 is_fail);
  recover_c: cover property (is_fail ##1 is_normal);
  frame_c: cover property (frame_ok && is_normal);

endmodule

`default_nettype wire

/* File: hss_pkg.sv */
`default_nettype none

package hss_pkg;
  typedef enum logic [2:0] {
    HSS_SLEEP = 3'b001,
    HSS_NORMAL = 3'b010,
    HSS_FAIL = 3'b100
  } hss_mode_e;

  typedef struct packed {
    logic [3:0] addr;
    logic wd;
    logic [10:0] data;
  } hss_word_s;

  typedef struct packed {
    logic stuck;
    logic modulo;
    logic wd_seq;
    logic wd_timeout;
  } hss_cause_s;
endpackage

`default_nettype wire

/* File: hss_regs.svh */
`ifndef HSS_REGS_SVH
`define HSS_REGS_SVH

`define HSS_CLK_MHZ 50
`define HSS_INIT_TIME_US 50
`define HSS_INIT_CYC (`HSS_INIT_TIME_US * `HSS_CLK_MHZ)
`define HSS_BLANK_TIME_US 10
`define HSS_BLANK_CYC (`HSS_BLANK_TIME_US * `HSS_CLK_MHZ)
`define HSS_WD_TIME_US 10000
`define HSS_WORD_BITS 16

`define HSS_OFS_STATUS 4'h0
`define HSS_OFS_CONFIG 4'h4
`define HSS_OFS_RXWORD 4'h8
`define HSS_CONFIG_RESET 32'h00000001
`define HSS_CFG_WD_EN 0

`define HSS_ADDR_INIT1 4'h0
`define HSS_ADDR_CH1 4'h2
`define HSS_ADDR_CH6 4'h7
`define HSS_ADDR_OUTCTL 4'h8
`define HSS_ADDR_INEN 4'hb
`define HSS_ADDR_TEST 4'hf
`define HSS_ADDR_QSTAT 4'h1
`define HSS_ADDR_LAST_DSF 4'h7
`define HSS_CH_ON_BIT 8
`define HSS_QS_FM_BIT 11
`define HSS_DSF_BIT 10
`define HSS_QS_RCF_BIT 5

`endif

/* File: hss_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none

module hss_spi_host (
  input wire logic core_clk,
  input wire logic spi_so,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_si
);
  logic wd_next;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
    wd_next = 1'b0;
  end

  // half a serial period, 80 ns
  task automatic half();
    repeat (4) @(posedge core_clk);
  endtask

  task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    spi_cs_n <= 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      spi_si <= tx[i];
      half();
      spi_sclk <= 1'b1;
      half();
      spi_sclk <= 1'b0;
      // host takes data at the falling edge
      rx = {rx[30:0], spi_so};
    end
    half();
    spi_cs_n <= 1'b1;
    // released line shows no stale bit
    spi_si <= ~tx[0];
    half();
  endtask

  // toggle bit inverted on each word
  task automatic send(input logic [3:0] a, input logic [10:0] d, input int n, output logic [31:0] rx);
    frame({16'ha5c3, a, wd_next, d}, n, rx);
    wd_next = ~wd_next;
  endtask
endmodule

`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic core_clk, rst, avs_read, avs_write, avs_waitrequest, wake_reset_n_pin, limp_home_pin;
  logic [3:0] avs_address, direct_channel_inputs, overcurrent_window_inputs;
  logic [31:0] avs_writedata, avs_readdata, rd, rx;
  logic spi_sclk, spi_cs_n, spi_si, spi_so, spi_so_oe, undervoltage, ocw_clr, so_line;
  logic [3:0] overtemp_fault, high_overcurrent_detect, severe_short_fault, overload_fault, autorestart_enable;
  logic [5:0] channel_control;
  logic [4:0] ocw_start, ocw_seen;
  logic overcurrent_max_profile, pwm_enable, analog_feedback_enable, fault_blank, init_done;
  int num_errors;
  int tests_run;

  hss_mode_ctrl #(.WD_TIMEOUT_CYC(2000)) DUT (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wake_reset_n_pin(wake_reset_n_pin), .limp_home_pin(limp_home_pin),
    .direct_channel_inputs(direct_channel_inputs), .overcurrent_window_inputs(overcurrent_window_inputs),
    .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_si(spi_si), .spi_so(spi_so), .spi_so_oe(spi_so_oe),
    .overtemp_fault(overtemp_fault), .high_overcurrent_detect(high_overcurrent_detect),
    .severe_short_fault(severe_short_fault), .overload_fault(overload_fault), .undervoltage(undervoltage),
    .channel_control(channel_control), .ocw_start(ocw_start), .overcurrent_max_profile(overcurrent_max_profile),
    .autorestart_enable(autorestart_enable), .pwm_enable(pwm_enable), .analog_feedback_enable(analog_feedback_enable),
    .fault_blank(fault_blank), .init_done(init_done));

  // an undriven output line shows the inverse, so a read while released cannot pass
  assign so_line = spi_so_oe ? spi_so : ~spi_so;
  hss_spi_host host (.core_clk(core_clk), .spi_so(so_line), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_si(spi_si));

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // window pulses are one cycle wide, so collect them
  always @(posedge core_clk) ocw_seen <= ocw_clr ? 5'h00 : (ocw_seen | ocw_start);

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic av_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    // waitrequest is judged at the rising edge, before that edge updates the slave
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask

  task automatic give_verdict();
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    give_verdict();
  end

  initial begin
    {rst, avs_read, avs_write, avs_address, avs_writedata} = {3'b100, 36'h0};
    {wake_reset_n_pin, limp_home_pin, direct_channel_inputs, overcurrent_window_inputs, ocw_clr} = '0;
    {overtemp_fault, high_overcurrent_detect, severe_short_fault, overload_fault, undervoltage} = '0;
    num_errors = 0;
    tests_run = 0;
    tick(3);
    rst <= 1'b0;
    tick(3);
    av_rd(4'h0, rd);
    check(rd[2:0], 3'h1, "sleep mode");
    check(channel_control, 6'h00, "outputs off");
    av_rd(4'h4, rd);
    check(rd, 32'h00000001, "config reset");
    av_wr(4'h4, 32'h00000000);
    av_wr(4'h0, 32'h00000002);
    av_rd(4'hc, rd);
    check(rd, 32'h00000000, "unmapped read");
    for (int i = 0; i < 4; i++) begin
      overcurrent_window_inputs <= 4'h1 << i;
      tick(10);
      av_rd(4'h0, rd);
      check(rd[3:0], 4'ha, "window wake");
    end
    overcurrent_window_inputs <= 4'h0;
    tick(10);
    av_rd(4'h0, rd);
    check(rd[3:0], 4'h1, "back to sleep");
    wake_reset_n_pin <= 1'b1;
    tick(20);
    check(fault_blank, 1'b1, "blank on");
    tick(600);
    check(fault_blank, 1'b0, "blank over");
    tick(1780);
    check(init_done, 1'b0, "init early");
    tick(200);
    check(init_done, 1'b1, "init done");
    ocw_clr <= 1'b1;
    tick(1);
    ocw_clr <= 1'b0;
    host.send(4'h2, 11'h100, 16, rx);
    tick(4);
    check(channel_control[0], 1'b1, "on bit ch1");
    host.send(4'h8, 11'h031, 16, rx);
    host.send(4'hb, 11'h010, 16, rx);
    direct_channel_inputs <= 4'b0110;
    tick(10);
    check(channel_control, 6'h35, "normal channels");
    check(ocw_seen, 5'h15, "window starts");
    check(pwm_enable, 1'b1, "pwm in normal");
    host.send(4'h2, 11'h100, 32, rx);
    check(rx[15:0], 16'ha5c3, "daisy chain");
    check(spi_so_oe, 1'b0, "so released");
    limp_home_pin <= 1'b1;
    tick(10);
    av_rd(4'h0, rd);
    check(rd[6:0], 7'h5c, "limp fail");
    check(channel_control, 6'h06, "fail channels");
    check({pwm_enable, analog_feedback_enable, overcurrent_max_profile}, 3'b001, "fail outputs");
    host.send(4'h0, 11'h001, 16, rx);
    host.send(4'h7, 11'h100, 16, rx);
    check(rx[15:12], 4'h0, "fail select write ignored");
    tick(4);
    check(channel_control[5], 1'b0, "fail write ignored");
    ocw_clr <= 1'b1;
    tick(1);
    ocw_clr <= 1'b0;
    overcurrent_window_inputs <= 4'h8;
    tick(10);
    check(ocw_seen[3], 1'b1, "fail window");
    overcurrent_window_inputs <= 4'h0;
    overload_fault <= 4'h1;
    tick(2);
    check(autorestart_enable, 4'h1, "overload restart");
    overload_fault <= 4'h0;
    undervoltage <= 1'b1;
    tick(2);
    check(autorestart_enable, 4'hf, "uv restart");
    undervoltage <= 1'b0;
    direct_channel_inputs <= 4'hf;
    {overtemp_fault, high_overcurrent_detect, severe_short_fault} <= {4'h2, 4'h4, 4'h8};
    tick(2);
    {overtemp_fault, high_overcurrent_detect, severe_short_fault} <= '0;
    tick(6);
    check(channel_control, 6'h01, "latched off");
    limp_home_pin <= 1'b0;
    direct_channel_inputs <= 4'h0;
    tick(10);
    host.wd_next = 1'b0;
    host.send(4'h2, 11'h000, 16, rx);
    host.send(4'h2, 11'h000, 16, rx);
    tick(4);
    av_rd(4'h0, rd);
    check(rd[2:0], 3'h2, "recovered");
    check(rd[8:7], 2'b11, "flags set");
    check(channel_control, 6'h00, "cleared");
    host.send(4'h0, 11'h001, 16, rx);
    host.send(4'h0, 11'h001, 16, rx);
    check({rx[15:12], rx[10], rx[5]}, 6'h07, "quick status");
    av_rd(4'h0, rd);
    check(rd[7], 1'b0, "rcf cleared");
    host.send(4'h2, 11'h100, 15, rx);
    av_rd(4'h0, rd);
    check(rd[6:4], 3'b111, "bit count fail");
    wake_reset_n_pin <= 1'b0;
    tick(10);
    av_rd(4'h0, rd);
    check(rd[5:0], 6'h01, "pin reset");
    wake_reset_n_pin <= 1'b1;
    tick(10);
    host.wd_next = 1'b0;
    host.send(4'h0, 11'h000, 16, rx);
    av_rd(4'h0, rd);
    check(rd[6:4], 3'b011, "stuck no diag");
    wake_reset_n_pin <= 1'b0;
    tick(10);
    wake_reset_n_pin <= 1'b1;
    tick(10);
    av_wr(4'h4, 32'h00000001);
    host.wd_next = 1'b0;
    host.send(4'h2, 11'h000, 16, rx);
    tick(2100);
    av_rd(4'h0, rd);
    check(rd[6:4], 3'b111, "toggle timeout");
    wake_reset_n_pin <= 1'b0;
    tick(10);
    wake_reset_n_pin <= 1'b1;
    tick(10);
    host.wd_next = 1'b0;
    host.send(4'h2, 11'h000, 16, rx);
    av_rd(4'h0, rd);
    check(rd[2:0], 3'h2, "toggle sequence ok");
    host.wd_next = 1'b0;
    host.send(4'h2, 11'h000, 16, rx);
    av_rd(4'h0, rd);
    check(rd[6:4], 3'b111, "toggle sequence");
    give_verdict();
  end
endmodule

`default_nettype wire
